// >>> flash_status_pkg.sv
// Shared constants for the flash write-status reporting link.
// Assumes a single 25 MHz clock shared by both ends.
package flash_status_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam int          BANK_W           = 2;
    localparam int          SECT_W           = 3;
    // Status word bit positions
    localparam int          POLL_POS         = 7;
    localparam int          TOGGLE_POS       = 6;
    localparam int          TIMEOUT_POS      = 5;
    localparam int          WINDOW_POS       = 3;
    localparam int          SECT_TOGGLE_POS  = 2;
    // Commands on the write path
    localparam logic [2:0]  CMD_PROGRAM      = 3'h1;
    localparam logic [2:0]  CMD_SECT_ERASE   = 3'h2;
    localparam logic [2:0]  CMD_CHIP_ERASE   = 3'h3;
    localparam logic [2:0]  CMD_SUSPEND      = 3'h4;
    localparam logic [2:0]  CMD_RESUME       = 3'h5;
    localparam logic [2:0]  CMD_RESET        = 3'h6;
    // Timing
    localparam int          CLK_HZ           = 25000000;
    localparam int          WINDOW_US        = 50;
    localparam int          WINDOW_CYC       = (WINDOW_US * (CLK_HZ / 1000000));
    localparam int          PROG_CYC         = 64;
    localparam int          ERASE_CYC        = 256;
    localparam int          PULSE_LIMIT      = 1024;
    localparam logic [7:0]  ARRAY_RESET      = 8'hff;
    // Host results
    localparam logic [1:0]  RES_BUSY         = 2'h0;
    localparam logic [1:0]  RES_DONE         = 2'h1;
    localparam logic [1:0]  RES_FAIL         = 2'h2;
endpackage : flash_status_pkg

// >>> flash_status_if.sv
// Link between the flash status device and its host controller.
// Assumes both ends run on the same clk; reads answer one cycle later.
`timescale 1ns/100ps
interface flash_status_if (
    input wire logic clk
);
    logic                                   wrStb;
    logic [2:0]                             wrCmd;
    logic [flash_status_pkg::ADDR_W-1:0]    wrAddr;
    logic [flash_status_pkg::DATA_W-1:0]    wrData;
    logic                                   rdStb;
    logic [flash_status_pkg::ADDR_W-1:0]    rdAddr;
    logic [flash_status_pkg::DATA_W-1:0]    statusWord;
    logic                                   rdValid;
    logic                                   ready;

    modport device (input wrStb, wrCmd, wrAddr, wrData, rdStb, rdAddr,
                    output statusWord, rdValid, ready);
    modport host   (output wrStb, wrCmd, wrAddr, wrData, rdStb, rdAddr,
                    input statusWord, rdValid, ready);
endinterface : flash_status_if

// >>> flash_status_device.sv
// Operation
// - Host reads status twice, compares toggle
// - Toggle stops; next read returns array data
// - Host rechecks toggle once timeout seen
// - Toggle after timeout means fail; reset
// - Host restarts double read after leaving
// - Timeout flag high past pulse limit
// - Programming zero to one halts, times out
// - Reset returns to read or suspend-read
// - Window bit 0 during acceptance, then 1
// - Each added sector erase restarts window; device ignores one for another bank
// - Host may skip window under 50 us
// - Window closed: only suspend accepted
// - Host checks window around added commands; this host never reads the window bit
// - Host gives valid address for status
// - Non-busy bank reads return array data
// - Suspend reads behave normally, ready unchanged
// - Each busy-bank read inverts toggle bit
// - Sector toggle only in selected sectors
//
// Flash device end: small array, embedded program/erase, status reads.
// Address: [7:6] bank, [5:3] sector, [2:0] word. Assumes one host.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/100ps
module flash_status_device #(
    parameter int WINDOW_CYCLES = flash_status_pkg::WINDOW_CYC,
    parameter int PROG_CYCLES   = flash_status_pkg::PROG_CYC,
    parameter int ERASE_CYCLES  = flash_status_pkg::ERASE_CYC,
    parameter int PULSE_LIMIT   = flash_status_pkg::PULSE_LIMIT
) (
    input  wire logic   clk,
    input  wire logic   reset,
    flash_status_if.device link,
    output logic        busy,
    output logic        failed
);
    typedef enum logic [5:0] {
        S_READ     = 6'h01,
        S_PROG     = 6'h02,
        S_WINDOW   = 6'h04,
        S_ERASE    = 6'h08,
        S_SUSPEND  = 6'h10,
        S_SUSPROG  = 6'h20
    } state_e;

    localparam int AW = flash_status_pkg::ADDR_W;
    localparam int DW = flash_status_pkg::DATA_W;

    logic [DW-1:0]  mem_ff [0:(1<<AW)-1];
    state_e         state_ff;
    state_e         nxt_state;
    logic [31:0]    timer_ff;
    logic [31:0]    pulses_ff;
    logic           timeout_ff;
    logic           halted_ff;
    logic           toggle_ff;
    logic           sectToggle_ff;
    logic [7:0]     sectSel_ff;
    logic [1:0]     bank_ff;
    logic [AW-1:0]  progAddr_ff;
    logic [DW-1:0]  progData_ff;
    logic           eraseChip_ff;
    logic [DW-1:0]  statusWord_ff;
    logic           rdValid_ff;
    logic           busy_ff;

    wire logic       opBusy     = (state_ff == S_PROG) || (state_ff == S_WINDOW) ||
                                  (state_ff == S_ERASE) || (state_ff == S_SUSPROG);
    wire logic [1:0] rdBank     = link.rdAddr[7:6];
    wire logic [2:0] rdSect     = link.rdAddr[5:3];
    wire logic       bankHit    = (rdBank == bank_ff);
    wire logic       sectHit    = sectSel_ff[rdSect];
    wire logic [DW-1:0] arrayWord = mem_ff[link.rdAddr];
    wire logic       badBits    = |(link.wrData & ~mem_ff[link.wrAddr]);
    wire logic       wrProg     = link.wrStb && (link.wrCmd == flash_status_pkg::CMD_PROGRAM);
    wire logic       wrSect     = link.wrStb && (link.wrCmd == flash_status_pkg::CMD_SECT_ERASE);
    wire logic       wrChip     = link.wrStb && (link.wrCmd == flash_status_pkg::CMD_CHIP_ERASE);
    wire logic       wrSusp     = link.wrStb && (link.wrCmd == flash_status_pkg::CMD_SUSPEND);
    wire logic       wrResume   = link.wrStb && (link.wrCmd == flash_status_pkg::CMD_RESUME);
    wire logic       wrReset    = link.wrStb && (link.wrCmd == flash_status_pkg::CMD_RESET);
    wire logic       opDone     = !timeout_ff && !halted_ff && (timer_ff == 32'h0);
    wire logic       hitLimit   = (pulses_ff == PULSE_LIMIT - 1);
    wire logic       progInSusp = (state_ff == S_SUSPROG);
    wire logic       inProg     = (state_ff == S_PROG) || progInSusp;

    // Status word composition for a busy-bank read
    logic [DW-1:0]   statusNow;
    always_comb begin
        statusNow = arrayWord;
        if (bankHit && inProg) begin
            statusNow = {~progData_ff[flash_status_pkg::POLL_POS], ~toggle_ff,
                         timeout_ff, 5'h00};
        end else if (bankHit && (state_ff == S_ERASE || state_ff == S_WINDOW)) begin
            statusNow = 8'h00;
            statusNow[flash_status_pkg::TOGGLE_POS]  = ~toggle_ff;
            statusNow[flash_status_pkg::TIMEOUT_POS] = timeout_ff;
            statusNow[flash_status_pkg::WINDOW_POS]  = (state_ff == S_ERASE);
            statusNow[flash_status_pkg::SECT_TOGGLE_POS] =
                sectHit ? ~sectToggle_ff : sectToggle_ff;
        end else if (bankHit && state_ff == S_SUSPEND && sectHit) begin
            statusNow = 8'h00;
            statusNow[flash_status_pkg::POLL_POS]        = 1'b1;
            statusNow[flash_status_pkg::TOGGLE_POS]      = toggle_ff;
            statusNow[flash_status_pkg::SECT_TOGGLE_POS] = ~sectToggle_ff;
        end
        // Otherwise array data: idle, non-busy bank or unselected sector in suspend
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_READ: begin
                if (wrProg) nxt_state = S_PROG;
                else if (wrSect) nxt_state = S_WINDOW;
                else if (wrChip) nxt_state = S_ERASE;
            end
            S_PROG: begin
                if (wrReset && timeout_ff) nxt_state = S_READ;
                else if (opDone) nxt_state = S_READ;
            end
            S_WINDOW: begin
                if (wrSusp) nxt_state = S_SUSPEND;
                else if (timer_ff == 32'h0) nxt_state = S_ERASE;
            end
            S_ERASE: begin
                if (wrReset && timeout_ff) nxt_state = S_READ;
                else if (wrSusp) nxt_state = S_SUSPEND;
                else if (opDone) nxt_state = S_READ;
            end
            S_SUSPEND: begin
                if (wrResume) nxt_state = S_ERASE;
                else if (wrProg) nxt_state = S_SUSPROG;
            end
            S_SUSPROG: begin
                if (wrReset && timeout_ff) nxt_state = S_SUSPEND;
                else if (opDone) nxt_state = S_SUSPEND;
            end
            default: nxt_state = S_READ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= S_READ;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Timer, pulse count and operation bookkeeping
    always_ff @(posedge clk) begin
        if (reset) begin
            timer_ff     <= 32'h0;
            pulses_ff    <= 32'h0;
            timeout_ff   <= 1'b0;
            halted_ff    <= 1'b0;
            sectSel_ff   <= 8'h00;
            bank_ff      <= 2'h0;
            progAddr_ff  <= '0;
            progData_ff  <= '0;
            eraseChip_ff <= 1'b0;
        end else if (nxt_state != state_ff && (state_ff == S_READ || state_ff == S_SUSPEND)
                     && (wrProg || wrSect || wrChip)) begin
            pulses_ff    <= 32'h0;
            timeout_ff   <= 1'b0;
            halted_ff    <= wrProg && badBits;
            progAddr_ff  <= link.wrAddr;
            progData_ff  <= link.wrData;
            eraseChip_ff <= wrProg ? eraseChip_ff : wrChip;    // Keep a suspended chip erase
            if (!wrProg) bank_ff <= link.wrAddr[7:6];
            else if (state_ff == S_READ) bank_ff <= link.wrAddr[7:6];
            sectSel_ff   <= wrChip ? 8'hff : (wrSect ? (8'h01 << link.wrAddr[5:3]) : sectSel_ff);
            timer_ff     <= wrProg ? 32'(PROG_CYCLES) :
                            (wrSect ? 32'(WINDOW_CYCLES) : 32'(ERASE_CYCLES));
        end else if (state_ff == S_WINDOW && wrSect && link.wrAddr[7:6] == bank_ff) begin
            sectSel_ff <= sectSel_ff | (8'h01 << link.wrAddr[5:3]);
            timer_ff   <= 32'(WINDOW_CYCLES);
        end else if (state_ff == S_WINDOW && nxt_state == S_ERASE) begin
            timer_ff   <= 32'(ERASE_CYCLES);
        end else if (state_ff == S_SUSPEND && nxt_state == S_SUSPROG) begin
            timer_ff   <= 32'(PROG_CYCLES);
        end else if (state_ff == S_SUSPEND && nxt_state == S_ERASE) begin
            // Resume restarts the erase count: a program in suspend may have used the timer
            timer_ff   <= 32'(ERASE_CYCLES);
            pulses_ff  <= 32'h0;
        end else if (opBusy && state_ff != S_WINDOW) begin
            if (timer_ff != 32'h0 && !halted_ff) timer_ff <= timer_ff - 32'h1;
            if (!timeout_ff) pulses_ff <= pulses_ff + 32'h1;
            if (hitLimit) timeout_ff <= 1'b1;
        end else if (state_ff == S_WINDOW && timer_ff != 32'h0) begin
            timer_ff <= timer_ff - 32'h1;
        end
        if (!reset && (nxt_state == S_READ) && (state_ff != S_READ)) begin
            timeout_ff <= 1'b0;
            halted_ff  <= 1'b0;
            sectSel_ff <= 8'h00;
        end
        if (!reset && state_ff == S_SUSPROG && nxt_state == S_SUSPEND) begin
            timeout_ff <= 1'b0;
            halted_ff  <= 1'b0;
        end
    end

    // Array writes on completion; a halted program never touches the cell
    always_ff @(posedge clk) begin
        for (int i = 0; i < (1<<AW); i++) begin
            if (reset) begin
                mem_ff[i] <= flash_status_pkg::ARRAY_RESET;
            end else if (inProg && opDone && i == int'(progAddr_ff)) begin
                mem_ff[i] <= mem_ff[i] & progData_ff;
            end else if (state_ff == S_ERASE && opDone
                         && (eraseChip_ff || (i[7:6] == bank_ff && sectSel_ff[i[5:3]]))) begin
                mem_ff[i] <= flash_status_pkg::ARRAY_RESET;
            end
        end
    end

    // Read path: one-cycle answer; toggle advances per busy-bank read, sector toggle per selected-sector read outside S_READ
    always_ff @(posedge clk) begin
        if (reset) begin
            statusWord_ff <= '0;
            rdValid_ff    <= 1'b0;
            toggle_ff     <= 1'b0;
            sectToggle_ff <= 1'b0;
            busy_ff       <= 1'b0;
        end else begin
            rdValid_ff <= link.rdStb;
            busy_ff    <= opBusy;
            if (link.rdStb) begin
                statusWord_ff <= statusNow;
                if (bankHit && opBusy) toggle_ff <= ~toggle_ff;
                if (bankHit && sectHit && state_ff != S_READ)
                    sectToggle_ff <= ~sectToggle_ff;
            end
        end
    end

    assign link.statusWord = statusWord_ff;
    assign link.rdValid    = rdValid_ff;
    assign link.ready      = 1'b1;   // Same in suspend as outside it
    assign busy            = busy_ff;
    assign failed          = timeout_ff;
endmodule : flash_status_device

// >>> flash_status_host.sv
// Host controller end: issues commands and runs the toggle-bit status poll.
// Command port: cmd/cmdAddr/cmdData/cmdStb and pollStb; result qualified by resultValid.
`timescale 1ns/100ps
module flash_status_host (
    input  wire logic        clk,
    input  wire logic        reset,
    flash_status_if.host     link,
    input  wire logic [2:0]  cmd,
    input  wire logic [7:0]  cmdAddr,
    input  wire logic [7:0]  cmdData,
    input  wire logic        cmdStb,
    input  wire logic        pollStb,
    output logic [1:0]       result,
    output logic             resultValid,
    output logic [7:0]       lastWord
);
    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_RD1   = 5'h02,
        H_RD2   = 5'h04,
        H_RD3   = 5'h08,
        H_WAIT  = 5'h10
    } state_e;

    state_e      state_ff;
    state_e      nxt_state;
    logic [1:0]  step_ff;
    logic        first_ff;
    logic        wrStb_ff;
    logic [2:0]  wrCmd_ff;
    logic [7:0]  wrAddr_ff;
    logic [7:0]  wrData_ff;
    logic        rdStb_ff;
    logic [7:0]  rdAddr_ff;
    logic [7:0]  pollAddr_ff;
    logic [1:0]  result_ff;
    logic        resultValid_ff;
    logic [7:0]  lastWord_ff;

    wire logic tog    = link.statusWord[flash_status_pkg::TOGGLE_POS];
    wire logic tmo    = link.statusWord[flash_status_pkg::TIMEOUT_POS];
    wire logic moved  = (tog != first_ff);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            H_IDLE:  if (pollStb) nxt_state = H_RD1;
            H_RD1:   nxt_state = H_WAIT;
            H_RD2:   nxt_state = H_WAIT;
            H_RD3:   nxt_state = H_WAIT;
            H_WAIT: begin
                if (link.rdValid) begin
                    if (step_ff == 2'h0) nxt_state = H_RD2;
                    else if (!moved) nxt_state = H_IDLE;
                    else if (tmo && step_ff == 2'h1) nxt_state = H_RD3;
                    else if (step_ff == 2'h2) nxt_state = H_IDLE;
                    else nxt_state = H_RD2;
                end
            end
            default: nxt_state = H_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff       <= H_IDLE;
            step_ff        <= 2'h0;
            first_ff       <= 1'b0;
            wrStb_ff       <= 1'b0;
            wrCmd_ff       <= 3'h0;
            wrAddr_ff      <= 8'h00;
            wrData_ff      <= 8'h00;
            rdStb_ff       <= 1'b0;
            rdAddr_ff      <= 8'h00;
            pollAddr_ff    <= 8'h00;
            result_ff      <= flash_status_pkg::RES_BUSY;
            resultValid_ff <= 1'b0;
            lastWord_ff    <= 8'h00;
        end else begin
            state_ff       <= nxt_state;
            resultValid_ff <= 1'b0;
            rdStb_ff       <= (nxt_state == H_RD1) || (nxt_state == H_RD2) ||
                              (nxt_state == H_RD3);
            rdAddr_ff      <= pollAddr_ff;
            wrStb_ff       <= 1'b0;
            if (cmdStb && state_ff == H_IDLE) begin
                wrStb_ff    <= 1'b1;
                wrCmd_ff    <= cmd;
                wrAddr_ff   <= cmdAddr;
                wrData_ff   <= cmdData;
                pollAddr_ff <= cmdAddr;
            end
            if (state_ff == H_IDLE && pollStb) step_ff <= 2'h0;
            if (state_ff == H_WAIT && link.rdValid) begin
                lastWord_ff <= link.statusWord;
                first_ff    <= tog;
                if (nxt_state == H_RD2 && step_ff == 2'h0) step_ff <= 2'h1;
                if (nxt_state == H_RD3) step_ff <= 2'h2;
                if (nxt_state == H_IDLE) begin
                    resultValid_ff <= 1'b1;
                    result_ff <= moved ? flash_status_pkg::RES_FAIL : flash_status_pkg::RES_DONE;
                    if (moved) begin
                        wrStb_ff <= 1'b1;
                        wrCmd_ff <= flash_status_pkg::CMD_RESET;
                    end
                end else if (nxt_state == H_RD2 && step_ff != 2'h0) begin
                    resultValid_ff <= 1'b1;                 // Still busy, no timeout
                    result_ff      <= flash_status_pkg::RES_BUSY;
                end
            end
        end
    end

    assign link.wrStb   = wrStb_ff;
    assign link.wrCmd   = wrCmd_ff;
    assign link.wrAddr  = wrAddr_ff;
    assign link.wrData  = wrData_ff;
    assign link.rdStb   = rdStb_ff;
    assign link.rdAddr  = rdAddr_ff;
    assign result       = result_ff;
    assign resultValid  = resultValid_ff;
    assign lastWord     = lastWord_ff;
endmodule : flash_status_host

// >>> flash_status_monitor.sv
// Concurrent checks on the link between the flash device and its host.
// Assumes one clock and the bench's synchronous active-high reset.
`timescale 1ns/100ps
module flash_status_monitor (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       wrStb,
    input wire logic [2:0] wrCmd,
    input wire logic [7:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic       rdStb,
    input wire logic [7:0] rdAddr,
    input wire logic [7:0] statusWord,
    input wire logic       rdValid,
    input wire logic       ready
);
    logic [7:0] prevWord_ff;
    logic [7:0] prevAddr_ff;
    logic [7:0] readAddr_ff;
    logic       havePrev_ff;
    logic       wrSeen_ff;
    logic       steady_ff;
    // A pair only counts when no write slipped in between the two reads
    wire        sameAddr = havePrev_ff && !wrSeen_ff && (readAddr_ff == prevAddr_ff);
    wire        toggled  = statusWord[flash_status_pkg::TOGGLE_POS]
                           != prevWord_ff[flash_status_pkg::TOGGLE_POS];
    wire        bothLate = statusWord[flash_status_pkg::TIMEOUT_POS]
                           && prevWord_ff[flash_status_pkg::TIMEOUT_POS];

    always_ff @(posedge clk) begin
        if (reset) begin
            prevWord_ff <= 8'h00;
            prevAddr_ff <= 8'h00;
            readAddr_ff <= 8'h00;
            havePrev_ff <= 1'h0;
            wrSeen_ff   <= 1'h0;
            steady_ff   <= 1'h0;
        end else begin
            if (rdStb) readAddr_ff <= rdAddr;
            if (rdValid) begin
                prevWord_ff <= statusWord;
                prevAddr_ff <= readAddr_ff;
                havePrev_ff <= 1'h1;
                steady_ff   <= sameAddr && !toggled;
            end
            wrSeen_ff <= wrStb ? 1'h1 : (rdValid ? 1'h0 : wrSeen_ff);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence readTaken;
        rdStb;
    endsequence
    sequence lateToggle;
        rdValid && sameAddr && toggled && bothLate;
    endsequence

    AST_READ_ANSWER: assert property (readTaken |=> rdValid)
        else $error("read answer missing one cycle after the strobe");
    AST_NO_STRAY_VALID: assert property (rdValid |-> $past(rdStb))
        else $error("read answer without a read strobe");
    AST_READY_HIGH: assert property (ready)
        else $error("ready output dropped");
    AST_STROBES_APART: assert property (!(rdStb && wrStb))
        else $error("read and write strobe together");
    AST_WRITE_PULSE: assert property (wrStb |=> !wrStb)
        else $error("write strobe longer than one cycle");
    AST_WORD_STANDS: assert property (!rdValid |-> $stable(statusWord))
        else $error("status word changed without a read answer");
    AST_STEADY_THEN_DATA: assert property (
        rdValid && steady_ff && sameAddr |-> statusWord == prevWord_ff)
        else $error("read after steady toggle bit not array data");
    AST_LATE_TOGGLE_ACTS: assert property (
        lateToggle |-> ##[1:6] (rdStb || (wrStb && wrCmd == flash_status_pkg::CMD_RESET)))
        else $error("toggling after timeout left unanswered");
endmodule : flash_status_monitor

// >>> flash_write_status_reporting_tb.sv
// Self-checking bench: host and device joined by the link, model in integers.
// Assumes shortened device counts and poll reading the last command address.
`timescale 1ns/100ps
module flash_write_status_reporting_tb;
    logic       clk;
    logic       reset;
    logic [2:0] cmd;
    logic [7:0] cmdAddr;
    logic [7:0] cmdData;
    logic       cmdStb;
    logic       pollStb;
    logic [1:0] result;
    logic       resultValid;
    logic [7:0] lastWord;
    logic       busy;
    logic       failed;
    int         fails;
    int         cmp_count;
    int         seed;
    int         mem [256];

    flash_status_if flash_status_if_inst (.clk(clk));
    flash_status_device #(.WINDOW_CYCLES(8), .PROG_CYCLES(8), .ERASE_CYCLES(16),
        .PULSE_LIMIT(32)) flash_status_device_inst (.clk(clk), .reset(reset),
        .link(flash_status_if_inst), .busy(busy), .failed(failed));
    flash_status_host flash_status_host_inst (.clk(clk), .reset(reset),
        .link(flash_status_if_inst), .cmd(cmd), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .cmdStb(cmdStb), .pollStb(pollStb), .result(result), .resultValid(resultValid),
        .lastWord(lastWord));
    flash_status_monitor flash_status_monitor_inst (.clk(clk), .reset(reset),
        .wrStb(flash_status_if_inst.wrStb), .wrCmd(flash_status_if_inst.wrCmd),
        .wrAddr(flash_status_if_inst.wrAddr), .wrData(flash_status_if_inst.wrData),
        .rdStb(flash_status_if_inst.rdStb), .rdAddr(flash_status_if_inst.rdAddr),
        .statusWord(flash_status_if_inst.statusWord),
        .rdValid(flash_status_if_inst.rdValid), .ready(flash_status_if_inst.ready));

    always #20 clk = ~clk;

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask : check

    // Host only takes a command while idle, so leave it a few cycles
    task automatic send(input logic [2:0] c, input logic [7:0] a, input logic [7:0] d);
        cmd     <= c;
        cmdAddr <= a;
        cmdData <= d;
        cmdStb  <= 1'h1;
        @(posedge clk);
        cmdStb  <= 1'h0;
        repeat (3) @(posedge clk);
    endtask : send

    // busyExp: first busy answer with both toggle bits masked off; ff means no busy answer
    task automatic poll(input logic [1:0] exp, input logic [7:0] a, input logic [7:0] busyExp);
        int         n;
        int         busyN;
        logic [7:0] firstBusy;
        pollStb <= 1'h1;
        @(posedge clk);
        pollStb <= 1'h0;
        n = 0;
        busyN = 0;
        firstBusy = 8'hff;
        while (!(resultValid === 1'h1 && result !== flash_status_pkg::RES_BUSY) && n < 3000) begin
            @(posedge clk);
            n++;
            if (resultValid === 1'h1 && result === flash_status_pkg::RES_BUSY) begin
                if (busyN == 0)
                    firstBusy = lastWord;
                busyN++;
            end
        end
        if (n >= 3000) begin
            check("poll bound", 8'h01, 8'h00);
            tally_and_finish();
        end
        check("result", {6'h00, result}, {6'h00, exp});
        if (exp == flash_status_pkg::RES_DONE)
            check("lastWord", lastWord, mem[a][7:0]);
        if (busyExp == 8'hff) begin
            check("busy reads", {7'h00, busyN != 0}, 8'h00);
        end else begin
            check("busy reads", {7'h00, busyN != 0}, 8'h01);
            check("busy word", firstBusy & 8'hbb, busyExp);
        end
        repeat (4) @(posedge clk);
        check("failed", {7'h00, failed}, 8'h00);
    endtask : poll

    // Programming can only clear bits; a 1 over a 0 must end in failure
    task automatic prog(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] exp;
        exp = ((d & ~mem[a][7:0]) != 8'h00) ? flash_status_pkg::RES_FAIL
                                             : flash_status_pkg::RES_DONE;
        if (exp == flash_status_pkg::RES_DONE)
            mem[a] = mem[a] & d;
        send(flash_status_pkg::CMD_PROGRAM, a, d);
        poll(exp, a, {~d[7], 7'h00});
    endtask : prog

    task automatic erase_sector(input logic [7:0] a);
        for (int i = 0; i < 8; i++)
            mem[{a[7:3], 3'h0} + i] = 8'hff;
        send(flash_status_pkg::CMD_SECT_ERASE, a, 8'h00);
    endtask : erase_sector

    initial begin
        clk = 1'h0;
        reset = 1'h1;
        cmd = 3'h0;
        cmdAddr = 8'h00;
        cmdData = 8'h00;
        cmdStb = 1'h0;
        pollStb = 1'h0;
        fails = 0;
        cmp_count = 0;
        seed = 20;
        foreach (mem[i])
            mem[i] = 8'hff;
        repeat (10) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        check("busy", {7'h00, busy}, 8'h00);
        check("failed", {7'h00, failed}, 8'h00);
        check("ready", {7'h00, flash_status_if_inst.ready}, 8'h01);
        check("result", {6'h00, result}, {6'h00, flash_status_pkg::RES_BUSY});
        $display("Test reset done");
        for (int k = 0; k < 6; k++)
            prog({2'h2, 6'($random(seed))}, 8'($random(seed)));
        $display("Test random program done");
        prog(8'h40, 8'h00);
        prog(8'h40, 8'h0f);
        $display("Test failing program done");
        erase_sector(8'h40);
        erase_sector(8'h48);
        poll(flash_status_pkg::RES_DONE, 8'h48, 8'h00);
        $display("Test sector erase done");
        prog(8'hc1, 8'h12);
        erase_sector(8'hc0);
        repeat (12) @(posedge clk);
        send(flash_status_pkg::CMD_SUSPEND, 8'hc0, 8'h00);
        prog(8'hc9, 8'h12);
        prog(8'hc9, 8'h21);
        send(flash_status_pkg::CMD_RESUME, 8'hc0, 8'h00);
        poll(flash_status_pkg::RES_DONE, 8'hc0, 8'h08);
        $display("Test suspend done");
        foreach (mem[i])
            mem[i] = 8'hff;
        send(flash_status_pkg::CMD_CHIP_ERASE, 8'h80, 8'h00);
        poll(flash_status_pkg::RES_DONE, 8'h80, 8'h08);
        poll(flash_status_pkg::RES_DONE, 8'h80, 8'hff);
        $display("Test chip erase done");
        tally_and_finish();
    end
endmodule : flash_write_status_reporting_tb
